// [fiapms_sequencer.sv]
// Mailbox driven in-application flash programming sequencer for a two block flash.
//
// Notes on behaviour
// - Commands are ignored while the configuration enable bit 6 is clear.
// - Only a command byte write launches an operation, using loaded mailboxes.
// - Block erase, sector erase, program and verify commands aimed at a locked block are refused.
// - Erase codes 01h chip, 0dh block, 0bh sector; chip and block need data 55h.
// - Program 0eh writes data byte; verify 0ch returns stored byte; both use address.
// - Security bit codes 0fh, 03h, 05h need data aah; address ignored.
// - Code 09h data aah: high 5ah first, aah second; 08h high 55h doubles clock.
// - Command bit 7 set gives internal interrupt completion; clear means polling.
// - Busy is status bit 2, high while running, low when ready.
// - Chip erase runs only with external access input 0 and not level 4.
// - Chip erase clears both blocks, security bits and remap bits regardless of locks.
// - Block erase: high bits 7..5 111b secondary, bit 7 clear primary.
// - Sector erase clears one 128 byte sector at the mailbox address.
// - Byte program writes the data byte at the mailbox address.
// - Verify is quick, sets no busy, raises no interrupt; software waits first.
// - Security bits take effect at completion, without reset.
// - Start config commands change only their bit; reset clears them, so boot select and config bit 1 load 0 after it.
// - After clock double the core runs six clocks per machine cycle.
// - Except chip erase, code in one block targets the other block, never itself.
// - Bank selection overlays the secondary block onto the lowest 8 KByte.
// - Program disable pin low on the first clock edge after reset release disables all commands.
`timescale 1ns/1ps
module fiapms_sequencer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Software mailbox writes.
    input wire logic [7:0] sw_wdata,
    input wire logic command_wr,
    input wire logic addr_high_wr,
    input wire logic addr_low_wr,
    input wire logic data_wr,
    input wire logic config_wr,
    // Device environment.
    input wire logic [1:0] fetch_origin,
    input wire logic external_access_n,
    input wire logic program_disable_pin_n,
    input wire logic security_level4,
    input wire logic [1:0] block_locked,
    input wire logic [7:0] flash_rdata,
    // Mailbox contents.
    output logic [7:0] flash_status_reg,
    output logic [7:0] flash_command_reg,
    output logic [7:0] flash_addr_high_reg,
    output logic [7:0] flash_addr_low_reg,
    output logic [7:0] flash_data_reg,
    output logic [7:0] flash_config_reg,
    // Flash macro control.
    output logic flash_op_start,
    output logic [2:0] flash_op_kind,
    output logic flash_op_block,
    output logic [15:0] flash_op_addr,
    output logic [7:0] flash_op_wdata,
    // Stored configuration.
    output logic [2:0] security_bits,
    output logic start_config_0,
    output logic start_config_1,
    output logic boot_select,
    output logic core_six_clock_mode,
    // Completion interrupt.
    output logic ext_irq_1,
    output logic ext_irq_1_pin_free
);

    fiapms_pkg::fiapms_state_e state_reg;
    fiapms_pkg::fiapms_state_e state_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] ah_reg, ah_next;
    logic [7:0] al_reg, al_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] cfg_reg, cfg_next;
    logic busy_reg, busy_next;
    logic start_reg, start_next;
    logic [2:0] kind_reg, kind_next;
    logic blk_reg, blk_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [2:0] sec_reg, sec_next;
    logic sc0_reg, sc0_next;
    logic sc1_reg, sc1_next;
    logic boot_reg, boot_next;
    logic dbl_reg, dbl_next;
    logic irq_reg, irq_next;
    logic pin_free_reg, pin_free_next;
    logic inhibit_reg, inhibit_next;
    logic armed_reg, armed_next;
    logic [2:0] cfg_action_reg, cfg_action_next;
    logic [11:0] load;
    logic done;

    // Decode of a command write against the mailboxes.
    logic cmd_valid;
    logic [2:0] cmd_kind;
    logic cmd_blk;
    logic cmd_needs_lock_check;
    logic [2:0] cmd_action;
    logic [15:0] mail_addr;
    logic overlay;
    logic addr_blk;
    logic implicit_blk;
    logic origin_internal;

    assign mail_addr = {ah_reg, al_reg};
    assign origin_internal = (fetch_origin == fiapms_pkg::ORIGIN_PRIMARY) ||
                             (fetch_origin == fiapms_pkg::ORIGIN_SECONDARY);

    // Overlay comes from the external access input and the bank bits; it only
    // matters for code running outside the flash.
    always_comb begin
        overlay = external_access_n ? cfg_reg[0] : cfg_reg[1];
        addr_blk = (overlay && (mail_addr[15:13] == 3'h0)) ?
                   fiapms_pkg::BLOCK_SECONDARY : fiapms_pkg::BLOCK_PRIMARY;
        if (fetch_origin == fiapms_pkg::ORIGIN_PRIMARY) begin
            implicit_blk = fiapms_pkg::BLOCK_SECONDARY;
        end else if (fetch_origin == fiapms_pkg::ORIGIN_SECONDARY) begin
            implicit_blk = fiapms_pkg::BLOCK_PRIMARY;
        end else begin
            implicit_blk = addr_blk;
        end
    end

    // Command code and key checks. Unknown codes or wrong keys decode as invalid.
    always_comb begin
        cmd_valid = 1'b0;
        cmd_kind = fiapms_pkg::FIAPMS_OP_NONE;
        cmd_blk = implicit_blk;
        cmd_needs_lock_check = 1'b1;
        cmd_action = 3'h0;
        unique case (sw_wdata[6:0])
            fiapms_pkg::CMD_CHIP_ERASE: begin
                cmd_valid = (data_reg == fiapms_pkg::KEY_ERASE) &&
                            !external_access_n && !security_level4;
                cmd_kind = fiapms_pkg::FIAPMS_OP_CHIP_ERASE;
                cmd_needs_lock_check = 1'b0;
            end
            fiapms_pkg::CMD_BLOCK_ERASE: begin
                if (ah_reg[7:5] == fiapms_pkg::SECONDARY_AH_TOP) begin
                    cmd_blk = fiapms_pkg::BLOCK_SECONDARY;
                    cmd_valid = (data_reg == fiapms_pkg::KEY_ERASE);
                end else if (!ah_reg[7]) begin
                    cmd_blk = fiapms_pkg::BLOCK_PRIMARY;
                    cmd_valid = (data_reg == fiapms_pkg::KEY_ERASE);
                end
                // A block may not erase the block that it runs from.
                if (origin_internal && (cmd_blk == fetch_origin[0])) begin
                    cmd_valid = 1'b0;
                end
                cmd_kind = fiapms_pkg::FIAPMS_OP_BLOCK_ERASE;
            end
            fiapms_pkg::CMD_SECTOR_ERASE: begin
                cmd_valid = 1'b1;
                cmd_kind = fiapms_pkg::FIAPMS_OP_SECTOR_ERASE;
            end
            fiapms_pkg::CMD_BYTE_PROG: begin
                cmd_valid = 1'b1;
                cmd_kind = fiapms_pkg::FIAPMS_OP_BYTE_PROG;
            end
            fiapms_pkg::CMD_BYTE_VERIFY: begin
                cmd_valid = 1'b1;
                cmd_kind = fiapms_pkg::FIAPMS_OP_BYTE_READ;
            end
            fiapms_pkg::CMD_SEC_BIT_A, fiapms_pkg::CMD_SEC_BIT_B,
            fiapms_pkg::CMD_SEC_BIT_C: begin
                cmd_valid = (data_reg == fiapms_pkg::KEY_CONFIG);
                cmd_kind = fiapms_pkg::FIAPMS_OP_CONFIG;
                cmd_needs_lock_check = 1'b0;
                cmd_action = (sw_wdata[6:0] == fiapms_pkg::CMD_SEC_BIT_A) ? 3'h1 :
                             (sw_wdata[6:0] == fiapms_pkg::CMD_SEC_BIT_B) ? 3'h2 : 3'h3;
            end
            fiapms_pkg::CMD_START_CFG: begin
                cmd_valid = (data_reg == fiapms_pkg::KEY_CONFIG) &&
                            ((ah_reg == fiapms_pkg::KEY_START_CFG_0) ||
                             (ah_reg == fiapms_pkg::KEY_START_CFG_1));
                cmd_kind = fiapms_pkg::FIAPMS_OP_CONFIG;
                cmd_needs_lock_check = 1'b0;
                cmd_action = (ah_reg == fiapms_pkg::KEY_START_CFG_0) ? 3'h4 : 3'h5;
            end
            fiapms_pkg::CMD_CLOCK_DOUBLE: begin
                cmd_valid = (data_reg == fiapms_pkg::KEY_CONFIG) &&
                            (ah_reg == fiapms_pkg::KEY_CLOCK_DOUBLE);
                cmd_kind = fiapms_pkg::FIAPMS_OP_CONFIG;
                cmd_needs_lock_check = 1'b0;
                cmd_action = 3'h6;
            end
            default: begin
                cmd_valid = 1'b0;
            end
        endcase
        // Configuration commands may not run from the primary block.
        if ((cmd_kind == fiapms_pkg::FIAPMS_OP_CONFIG) &&
            (fetch_origin == fiapms_pkg::ORIGIN_PRIMARY)) begin
            cmd_valid = 1'b0;
        end
        if (cmd_needs_lock_check && block_locked[cmd_blk]) begin
            cmd_valid = 1'b0;
        end
    end

    // Operation time handed to the timer.
    always_comb begin
        unique case (kind_reg)
            fiapms_pkg::FIAPMS_OP_CHIP_ERASE: load = fiapms_pkg::CHIP_ERASE_CYC;
            fiapms_pkg::FIAPMS_OP_BLOCK_ERASE: load = fiapms_pkg::BLOCK_ERASE_CYC;
            fiapms_pkg::FIAPMS_OP_SECTOR_ERASE: load = fiapms_pkg::SECTOR_ERASE_CYC;
            fiapms_pkg::FIAPMS_OP_BYTE_PROG: load = fiapms_pkg::BYTE_PROG_CYC;
            default: load = fiapms_pkg::CONFIG_PROG_CYC;
        endcase
    end

    fiapms_op_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(start_reg && (kind_reg != fiapms_pkg::FIAPMS_OP_BYTE_READ)),
        .load(load),
        .done(done)
    );

    // Sequencer and mailbox next state. The disable pin is caught on the first
    // edge after reset release, because an asynchronous reset may only load constants.
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        ah_next = addr_high_wr ? sw_wdata : ah_reg;
        al_next = addr_low_wr ? sw_wdata : al_reg;
        data_next = data_wr ? sw_wdata : data_reg;
        cfg_next = config_wr ? sw_wdata : cfg_reg;
        busy_next = busy_reg;
        start_next = 1'b0;
        kind_next = kind_reg;
        blk_next = blk_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        sec_next = sec_reg;
        sc0_next = sc0_reg;
        sc1_next = sc1_reg;
        boot_next = boot_reg;
        dbl_next = dbl_reg;
        irq_next = 1'b0;
        pin_free_next = pin_free_reg;
        inhibit_next = inhibit_reg;
        armed_next = 1'b1;
        cfg_action_next = cfg_action_reg;
        if (!armed_reg) begin
            inhibit_next = !program_disable_pin_n;
            boot_next = sc0_reg;
            cfg_next[1] = sc1_reg;
        end
        unique case (state_reg)
            fiapms_pkg::FIAPMS_IDLE: begin
                if (command_wr) begin
                    cmd_next = sw_wdata;
                end
                if (command_wr && armed_reg && cmd_valid && !inhibit_reg &&
                    cfg_reg[fiapms_pkg::CFG_ENABLE_BIT]) begin
                    start_next = 1'b1;
                    kind_next = cmd_kind;
                    blk_next = cmd_blk;
                    addr_next = mail_addr;
                    wdata_next = data_reg;
                    cfg_action_next = cmd_action;
                    if (cmd_kind == fiapms_pkg::FIAPMS_OP_BYTE_READ) begin
                        state_next = fiapms_pkg::FIAPMS_VERIFY;
                    end else begin
                        state_next = fiapms_pkg::FIAPMS_RUN;
                        busy_next = 1'b1;
                        pin_free_next = sw_wdata[fiapms_pkg::CMD_IRQ_BIT];
                    end
                end
            end
            fiapms_pkg::FIAPMS_RUN: begin
                if (done) begin
                    state_next = fiapms_pkg::FIAPMS_IDLE;
                    busy_next = 1'b0;
                    irq_next = cmd_reg[fiapms_pkg::CMD_IRQ_BIT];
                    pin_free_next = 1'b0;
                    if (kind_reg == fiapms_pkg::FIAPMS_OP_CHIP_ERASE) begin
                        sec_next = 3'h0;
                        cfg_next[1:0] = 2'h0;
                    end
                    if (kind_reg == fiapms_pkg::FIAPMS_OP_CONFIG) begin
                        unique case (cfg_action_reg)
                            3'h1: sec_next[0] = 1'b1;
                            3'h2: sec_next[1] = 1'b1;
                            3'h3: sec_next[2] = 1'b1;
                            3'h4: sc0_next = 1'b1;
                            3'h5: sc1_next = 1'b1;
                            3'h6: dbl_next = 1'b1;
                            default: dbl_next = dbl_reg;
                        endcase
                    end
                end
            end
            fiapms_pkg::FIAPMS_VERIFY: begin
                // The macro presents the byte in the same cycle as the read request.
                data_next = flash_rdata;
                state_next = fiapms_pkg::FIAPMS_IDLE;
            end
            default: begin
                state_next = fiapms_pkg::FIAPMS_IDLE;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= fiapms_pkg::FIAPMS_IDLE;
            cmd_reg <= fiapms_pkg::RESET_BYTE;
            ah_reg <= fiapms_pkg::RESET_BYTE;
            al_reg <= fiapms_pkg::RESET_BYTE;
            data_reg <= fiapms_pkg::RESET_BYTE;
            cfg_reg <= fiapms_pkg::RESET_BYTE;
            busy_reg <= 1'b0;
            start_reg <= 1'b0;
            kind_reg <= fiapms_pkg::FIAPMS_OP_NONE;
            blk_reg <= fiapms_pkg::BLOCK_PRIMARY;
            addr_reg <= 16'h0000;
            wdata_reg <= fiapms_pkg::RESET_BYTE;
            sec_reg <= 3'h0;
            sc0_reg <= 1'b0;
            sc1_reg <= 1'b0;
            boot_reg <= 1'b0;
            dbl_reg <= 1'b0;
            irq_reg <= 1'b0;
            pin_free_reg <= 1'b0;
            inhibit_reg <= 1'b1;
            armed_reg <= 1'b0;
            cfg_action_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            ah_reg <= ah_next;
            al_reg <= al_next;
            data_reg <= data_next;
            cfg_reg <= cfg_next;
            busy_reg <= busy_next;
            start_reg <= start_next;
            kind_reg <= kind_next;
            blk_reg <= blk_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            sec_reg <= sec_next;
            sc0_reg <= sc0_next;
            sc1_reg <= sc1_next;
            boot_reg <= boot_next;
            dbl_reg <= dbl_next;
            irq_reg <= irq_next;
            pin_free_reg <= pin_free_next;
            inhibit_reg <= inhibit_next;
            armed_reg <= armed_next;
            cfg_action_reg <= cfg_action_next;
        end
    end

    // Outputs straight from flip-flops.
    assign flash_status_reg = {5'h00, busy_reg, 2'h0};
    assign flash_command_reg = cmd_reg;
    assign flash_addr_high_reg = ah_reg;
    assign flash_addr_low_reg = al_reg;
    assign flash_data_reg = data_reg;
    assign flash_config_reg = cfg_reg;
    assign flash_op_start = start_reg;
    assign flash_op_kind = kind_reg;
    assign flash_op_block = blk_reg;
    assign flash_op_addr = addr_reg;
    assign flash_op_wdata = wdata_reg;
    assign security_bits = sec_reg;
    assign start_config_0 = sc0_reg;
    assign start_config_1 = sc1_reg;
    assign boot_select = boot_reg;
    assign core_six_clock_mode = dbl_reg;
    assign ext_irq_1 = irq_reg;
    assign ext_irq_1_pin_free = pin_free_reg;

endmodule : fiapms_sequencer

// [fiapms_pkg.sv]
// Constants, command codes and state types for the flash programming mailbox sequencer.
package fiapms_pkg;

    // Clock period of clk_sys, in ns.
    localparam int CLK_PERIOD_NS = 10;

    // Operation times in their own unit, as timing references for the flash macro.
    localparam int CHIP_ERASE_TIME_NS = 40000;
    localparam int BLOCK_ERASE_TIME_NS = 30000;
    localparam int SECTOR_ERASE_TIME_NS = 20000;
    localparam int BYTE_PROG_TIME_NS = 5000;
    localparam int CONFIG_PROG_TIME_NS = 5000;

    // Least times round up to whole cycles.
    localparam logic [11:0] CHIP_ERASE_CYC =
        12'((CHIP_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] BLOCK_ERASE_CYC =
        12'((BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SECTOR_ERASE_CYC =
        12'((SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] BYTE_PROG_CYC =
        12'((BYTE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CONFIG_PROG_CYC =
        12'((CONFIG_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Command codes in the low seven bits of the command byte.
    localparam logic [6:0] CMD_CHIP_ERASE = 7'h01;
    localparam logic [6:0] CMD_BLOCK_ERASE = 7'h0d;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0b;
    localparam logic [6:0] CMD_BYTE_PROG = 7'h0e;
    localparam logic [6:0] CMD_BYTE_VERIFY = 7'h0c;
    localparam logic [6:0] CMD_SEC_BIT_A = 7'h0f;
    localparam logic [6:0] CMD_SEC_BIT_B = 7'h03;
    localparam logic [6:0] CMD_SEC_BIT_C = 7'h05;
    localparam logic [6:0] CMD_START_CFG = 7'h09;
    localparam logic [6:0] CMD_CLOCK_DOUBLE = 7'h08;

    // Key values that the mailboxes must hold.
    localparam logic [7:0] KEY_ERASE = 8'h55;
    localparam logic [7:0] KEY_CONFIG = 8'haa;
    localparam logic [7:0] KEY_START_CFG_0 = 8'h5a;
    localparam logic [7:0] KEY_START_CFG_1 = 8'haa;
    localparam logic [7:0] KEY_CLOCK_DOUBLE = 8'h55;

    // Field positions.
    localparam int CMD_IRQ_BIT = 7;
    localparam int CFG_ENABLE_BIT = 6;
    localparam int STATUS_BUSY_BIT = 2;
    localparam logic [2:0] SECONDARY_AH_TOP = 3'h7;

    // Values after reset.
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Code fetch origin.
    localparam logic [1:0] ORIGIN_PRIMARY = 2'h0;
    localparam logic [1:0] ORIGIN_SECONDARY = 2'h1;

    // Block numbers.
    localparam logic BLOCK_PRIMARY = 1'b0;
    localparam logic BLOCK_SECONDARY = 1'b1;

    // Operation kinds shown to the flash macro.
    typedef enum logic [2:0] {
        FIAPMS_OP_NONE = 3'b000,
        FIAPMS_OP_CHIP_ERASE = 3'b001,
        FIAPMS_OP_BLOCK_ERASE = 3'b010,
        FIAPMS_OP_SECTOR_ERASE = 3'b011,
        FIAPMS_OP_BYTE_PROG = 3'b100,
        FIAPMS_OP_BYTE_READ = 3'b101,
        FIAPMS_OP_CONFIG = 3'b110
    } fiapms_op_e;

    // Sequencer states.
    typedef enum logic [1:0] {
        FIAPMS_IDLE = 2'b00,
        FIAPMS_RUN = 2'b01,
        FIAPMS_VERIFY = 2'b10
    } fiapms_state_e;

endpackage : fiapms_pkg

// [fiapms_op_timer.sv]
// Down counter that times one flash operation and pulses when it ends.
`timescale 1ns/1ps
module fiapms_op_timer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Control.
    input wire logic start,
    input wire logic [11:0] load,
    // Status.
    output logic done
);

    logic [11:0] count_reg;
    logic [11:0] count_next;
    logic run_reg;
    logic run_next;
    logic done_reg;
    logic done_next;

    // A start reloads the counter even while running; the sequencer never does that.
    always_comb begin
        count_next = count_reg;
        run_next = run_reg;
        done_next = 1'b0;
        if (start) begin
            count_next = load;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (count_reg <= 12'h001) begin
                run_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - 12'h001;
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= 12'h000;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg <= run_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

endmodule : fiapms_op_timer

// [fiapms_sequencer_monitor.sv]
// Port checker for the flash programming sequencer.
`timescale 1ns/1ps
module fiapms_sequencer_monitor (
    // Clock, reset and inputs.
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic command_wr,
    input wire logic [1:0] fetch_origin,
    input wire logic external_access_n,
    input wire logic security_level4,
    input wire logic [1:0] block_locked,
    // Outputs.
    input wire logic [7:0] flash_status_reg,
    input wire logic [7:0] flash_config_reg,
    input wire logic flash_op_start,
    input wire logic [2:0] flash_op_kind,
    input wire logic flash_op_block,
    input wire logic ext_irq_1,
    input wire logic ext_irq_1_pin_free
);
    // One clock domain, so clock and reset are stated once.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire busy = flash_status_reg[2];
    wire st_k = flash_op_start && flash_op_kind inside {3'h2, 3'h3, 3'h4, 3'h5};
    // Properties tie each output moment to its cause.
    property p_off; command_wr && !flash_config_reg[6] |=> !flash_op_start; endproperty
    property p_cause; $rose(busy) |-> $past(command_wr); endproperty
    property p_busy; flash_op_start && flash_op_kind != 3'h5 |-> busy; endproperty
    property p_prog; flash_op_start && flash_op_kind == 3'h4 |-> ##300 busy ##201 busy ##1 !busy;
    endproperty
    property p_irq; ext_irq_1 |-> $fell(busy) && $past(ext_irq_1_pin_free); endproperty
    property p_vfy; flash_op_start && flash_op_kind == 3'h5 |-> (!busy && !ext_irq_1) [*3];
    endproperty
    property p_lock; st_k |-> !block_locked[flash_op_block]; endproperty
    property p_chip; flash_op_start && flash_op_kind == 3'h1 |->
        !$past(external_access_n) && !$past(security_level4); endproperty
    property p_self; st_k && $past(fetch_origin) < 2'h2 |->
        flash_op_block != ($past(fetch_origin) == 2'h1); endproperty
    a_off: assert property (p_off) else $error("start after disabled command");
    a_cause: assert property (p_cause) else $error("busy without command");
    a_busy: assert property (p_busy) else $error("busy missing at start");
    a_prog: assert property (p_prog) else $error("program time wrong");
    a_irq: assert property (p_irq) else $error("irq not at busy fall");
    a_vfy: assert property (p_vfy) else $error("verify set busy or irq");
    a_lock: assert property (p_lock) else $error("locked block started");
    a_chip: assert property (p_chip) else $error("chip erase not allowed");
    a_self: assert property (p_self) else $error("block targets itself");
    // Main scenarios reached.
    c_irq: cover property (ext_irq_1);
    c_vfy: cover property (flash_op_start && flash_op_kind == 3'h5);
    c_chip: cover property (flash_op_start && flash_op_kind == 3'h1);
endmodule : fiapms_sequencer_monitor

bind fiapms_sequencer fiapms_sequencer_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
    .command_wr(command_wr), .fetch_origin(fetch_origin),
    .external_access_n(external_access_n), .security_level4(security_level4),
    .block_locked(block_locked), .flash_status_reg(flash_status_reg),
    .flash_config_reg(flash_config_reg), .flash_op_start(flash_op_start),
    .flash_op_kind(flash_op_kind), .flash_op_block(flash_op_block),
    .ext_irq_1(ext_irq_1), .ext_irq_1_pin_free(ext_irq_1_pin_free));

// [fiapms_sequencer_bench.sv]
// Self-checking bench of the flash programming sequencer.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module fiapms_sequencer_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ea_n = 1'b1;
    logic [4:0] wv = 5'h0;
    logic [7:0] wd = 8'h0, rd = 8'h0, a_h, a_l, d, st, dt, wdo, cr;
    logic pd_n = 1'b1, lv4 = 1'b0;
    logic [7:0] codes [3] = '{8'h0f, 8'h03, 8'h05};
    logic [1:0] org = 2'h0, lk = 2'h0;
    logic go, blk, irq, sc0, sc1, bs, six, pf;
    logic [2:0] kd, sb;
    logic [15:0] ad;
    logic [27:0] q [$];
    logic [27:0] n;
    int errors = 0;
    int checks_done = 0;
    fiapms_sequencer dut (.clk_sys(clk_sys), .rst(rst), .sw_wdata(wd), .command_wr(wv[0]),
        .addr_high_wr(wv[1]), .addr_low_wr(wv[2]), .data_wr(wv[3]), .config_wr(wv[4]),
        .fetch_origin(org), .external_access_n(ea_n), .program_disable_pin_n(pd_n),
        .security_level4(lv4), .block_locked(lk), .flash_rdata(rd), .flash_status_reg(st),
        .flash_command_reg(cr), .flash_addr_high_reg(), .flash_addr_low_reg(),
        .flash_data_reg(dt), .flash_config_reg(), .flash_op_start(go), .flash_op_kind(kd),
        .flash_op_block(blk), .flash_op_addr(ad), .flash_op_wdata(wdo), .security_bits(sb),
        .start_config_0(sc0), .start_config_1(sc1), .boot_select(bs),
        .core_six_clock_mode(six), .ext_irq_1(irq), .ext_irq_1_pin_free(pf));
    // Free running 100 MHz clock.
    initial forever #5 clk_sys = ~clk_sys;
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // One mailbox write; selector 0 command, 1 high, 2 low, 3 data, 4 config.
    task automatic wr(input int s, input logic [7:0] v);
        @(posedge clk_sys);
        #1 wv = 5'(1 << s);
        wd = v;
        @(posedge clk_sys);
        #1 wv = 5'h0;
    endtask : wr
    // Issues a command and follows busy, bounded, until it drops.
    task automatic cmd(input logic [7:0] v, input logic ok);
        int k;
        k = 0;
        wr(0, v);
        `CHK("busy", ok, st[2])
        `CHK("cmdreg", v, cr)
        `CHK("pinfree", ok & v[7], pf)
        while (st[2] === 1'b1 && k < 5000) begin
            @(posedge clk_sys);
            #1 k++;
        end
        `CHK("idle", 1'b0, st[2])
        if (ok) `CHK("irq", v[7], irq)
    endtask : cmd
    // Each macro start takes the oldest note; kind always, target where it matters.
    always @(negedge clk_sys) begin
        if (go === 1'b1) begin
            n = q.pop_front();
            `CHK("kind", n[27:25], kd)
            if (n[27:25] == 3'h2 || n[27:25] == 3'h4) `CHK("blk", n[24], blk)
            if (n[27:25] == 3'h4) `CHK("addr", n[23:0], {ad, wdo})
        end
    end
    // A hang counts as a mismatch; the run needs about 13000 cycles.
    initial begin
        #400000 errors++;
        conclude();
    end
    // Scenarios, with the expected start of each operation noted first.
    initial begin
        void'($urandom(32'hb77b));
        a_h = 8'($urandom);
        a_l = 8'($urandom);
        d = 8'($urandom);
        rd = 8'($urandom);
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        wr(1, a_h);
        wr(2, a_l);
        wr(3, d);
        cmd(8'h8e, 1'b0);
        wr(4, 8'h40);
        lk = 2'h2;
        cmd(8'h8e, 1'b0);
        lk = 2'h0;
        q.push_back({3'h4, 1'b1, a_h, a_l, d});
        cmd(8'h8e, 1'b1);
        org = 2'h1;
        q.push_back({3'h5, 25'h0});
        cmd(8'h0c, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("verify", rd, dt)
        org = 2'h0;
        q.push_back({3'h3, 25'h0});
        cmd(8'h0b, 1'b1);
        wr(3, 8'h55);
        wr(1, 8'he0);
        q.push_back({3'h2, 1'b1, 24'h0});
        cmd(8'h0d, 1'b1);
        org = 2'h1;
        wr(3, 8'haa);
        for (int i = 0; i < 3; i++) begin
            q.push_back({3'h6, 25'h0});
            cmd(codes[i], 1'b1);
            `CHK("secbit", 1'b1, sb[i])
        end
        wr(1, 8'h5a);
        q.push_back({3'h6, 25'h0});
        cmd(8'h09, 1'b1);
        `CHK("sc0", 1'b1, sc0)
        `CHK("boot", 1'b0, bs)
        wr(1, 8'haa);
        q.push_back({3'h6, 25'h0});
        cmd(8'h09, 1'b1);
        `CHK("sc1", 1'b1, sc1)
        wr(1, 8'h55);
        q.push_back({3'h6, 25'h0});
        cmd(8'h88, 1'b1);
        `CHK("six", 1'b1, six)
        wr(3, 8'h55);
        org = 2'h2;
        cmd(8'h01, 1'b0);
        ea_n = 1'b0;
        lv4 = 1'b1;
        cmd(8'h01, 1'b0);
        lv4 = 1'b0;
        q.push_back({3'h1, 25'h0});
        cmd(8'h81, 1'b1);
        `CHK("secclr", 3'h0, sb)
        // A reset with the disable pin low must leave every command refused.
        pd_n = 1'b0;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        wr(4, 8'h40);
        cmd(8'h0b, 1'b0);
        `CHK("left", 0, q.size())
        conclude();
    end
endmodule : fiapms_sequencer_bench
